// File: src/vbs_map.svh
// Offsets, field positions, reset values and fixed codes of the slicer setup.
// Assumes it is included by bare name; definitions only.
`ifndef VBS_MAP_SVH
`define VBS_MAP_SVH

// ------------------------------------------------------------------
// Subaddresses
// ------------------------------------------------------------------
`define VBS_ADDR_CTRL 8'h40
`define VBS_ADDR_LINE_FIRST 8'h41
`define VBS_ADDR_LINE_LAST 8'h57
`define VBS_ADDR_FRAME_CODE 8'h58
`define VBS_ADDR_HOR_LOW 8'h59
`define VBS_ADDR_VER_LOW 8'h5a
`define VBS_ADDR_MSBS 8'h5b
`define VBS_ADDR_HEADER_ID 8'h5d
`define VBS_ADDR_SEC_ID 8'h5e

// ------------------------------------------------------------------
// Field positions and writable bit masks
// ------------------------------------------------------------------
`define VBS_BIT_PARITY_DIS 6
`define VBS_BIT_EXACT_CODE 5
`define VBS_BIT_SEARCH_STOP 4
`define VBS_BIT_FIELD_INV 7
`define VBS_BIT_RECODE 6
`define VBS_BIT_VER_MSB 4
`define VBS_BIT_REF_SEL 7
`define VBS_MASK_CTRL 8'h70
`define VBS_MASK_MSBS 8'hd7
`define VBS_MASK_HEADER_ID 8'hbf
`define VBS_MASK_SEC_ID 8'h3f

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define VBS_RST_LINE 8'hff
`define VBS_RST_FRAME_CODE 8'h40
`define VBS_RST_OTHER 8'h00

// ------------------------------------------------------------------
// Fixed framing codes, their lengths in bits, and line limits
// ------------------------------------------------------------------
`define VBS_CODE_TEXT 24'h000027
`define VBS_CODE_CAPTION 24'h000001
`define VBS_CODE_PROGRAM 24'h009951
`define VBS_CODE_WIDE 24'h1e3c1f
`define VBS_LEN_BYTE 5'h08
`define VBS_LEN_CAPTION 5'h03
`define VBS_LEN_PROGRAM 5'h10
`define VBS_LEN_WIDE 5'h18
`define VBS_LINE_FIRST 9'h002
`define VBS_LINE_LAST 9'h018
`define VBS_ID_SAV_RT 6'h3e
`define VBS_ID_SAV_TABLE 6'h3f
`define VBS_BYTE_LOW 8'h00
`define VBS_BYTE_HIGH 8'hff
`define VBS_BYTE_LOW_SUB 8'h03
`define VBS_BYTE_HIGH_SUB 8'hfc

`endif

// File: src/vbs_pkg.sv
// Types shared by the slicer setup logic.
// Assumes the map header supplies all numeric constants.
package vbs_pkg;

    // Data type codes held in each nibble of a line type register.
    typedef enum logic [3:0] {
        TYPE_EURO_TEXT = 4'h0, TYPE_EURO_CAPTION = 4'h1,
        TYPE_PROGRAM = 4'h2, TYPE_WIDE = 4'h3,
        TYPE_US_TEXT = 4'h4, TYPE_US_CAPTION = 4'h5,
        TYPE_TEST = 4'h6, TYPE_RAW = 4'h7,
        TYPE_GEN_TEXT = 4'h8, TYPE_EURO_TIME = 4'h9,
        TYPE_US_TIME = 4'ha, TYPE_RESERVED = 4'hb,
        TYPE_NET_TEXT = 4'hc, TYPE_JP_TEXT = 4'hd,
        TYPE_JP_SWITCH = 4'he, TYPE_ACTIVE = 4'hf
    } vbs_dtype_e;

    // Per-line framing setup handed to the slicer.
    typedef struct packed {
        logic parityCheck;
        logic exactCode;
        logic searchStop;
        logic [4:0] codeLen;
        logic [23:0] code;
    } vbs_frame_s;

    // Per-line status as seen by the slicer.
    typedef struct packed {
        logic field;
        logic [8:0] line;
        logic [3:0] dtype;
    } vbs_status_s;

    // Static setup handed to the slicer and output formatter.
    typedef struct packed {
        logic [10:0] horOffset;
        logic [8:0] verOffset;
        logic savEav;
        logic [5:0] headerId;
        logic [5:0] secId;
    } vbs_cfg_s;

endpackage : vbs_pkg

// File: src/vbs_slicer_control.sv
// Slicer setup registers, per-line type lookup and sliced byte path.
// Assumes a synchronous subaddress port and decoder timing strobes.
//
// Behaviour
// - Check parity of two bytes after framing code for types 0000 and 0100 unless disabled.
// - Policy bit clear allows one framing code bit error; set needs exact.
// - Amplitude search runs while stop bit clear; set freezes it.
// - One line type register per line 2..24; high nibble for slicer field 0.
// - Types 0000 and 0100 search framing code 27H.
// - Types 0001 and 0101 use framing pattern 001.
// - Type 0010 uses framing code 9951H.
// - Type 0011 uses framing code 1E3C1FH.
// - Types 1000,1001,1010,1101,1110 use the programmable framing code.
// - Types 0110,0111,1011,1100,1111 have no framing code; 1111 default.
// - Programmable framing code is 8 bits, reset 40H.
// - Horizontal offset is 11 bits split over two registers.
// - Vertical offset is 9 bits, low byte plus separate top bit.
// - Field offset bit set inverts the field indicator.
// - Recode turns data 00H into 03H and FFH into FCH.
// - Reference select picks table or real-time field and blank.
// - Identifier 00H gives header framing; 3EH and 3FH give SAV/EAV.
// - Secondary identifier of 6 bits, reset 00H, goes into header.
// - Each line reports slicer field, 9-bit line number and type.
`timescale 1ns/1ps
`include "vbs_map.svh"

// ------------------------------------------------------------------
// Byte FIFO between the slicer and the output formatter
// ------------------------------------------------------------------
module vbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Pointers wrap naturally, so the depth must be a power of two.
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("vbs_fifo: depth must be a power of two of 2 or more");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff, rdPtr_ff;
    logic [CW-1:0] count_ff, nxt_count;
    logic notFull_ff, notEmpty_ff, push, pop;

    // Handshakes and the next fill level.
    assign push = inValid && notFull_ff;
    assign pop = notEmpty_ff && outReady;
    assign nxt_count = count_ff + CW'(push) - CW'(pop);
    assign inReady = notFull_ff;
    assign outValid = notEmpty_ff;
    assign outData = mem_ff[rdPtr_ff];

    // Storage write.
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    // Pointers, level and registered full and empty flags.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            notFull_ff <= 1'b1;
            notEmpty_ff <= 1'b0;
        end else begin
            wrPtr_ff <= wrPtr_ff + AW'(push);
            rdPtr_ff <= rdPtr_ff + AW'(pop);
            count_ff <= nxt_count;
            notFull_ff <= nxt_count != CW'(DEPTH);
            notEmpty_ff <= nxt_count != '0;
        end
    end
endmodule : vbs_fifo

// ------------------------------------------------------------------
// Top: register bank, line lookup and byte path
// ------------------------------------------------------------------
module vbs_slicer_control #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] subAddr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    input wire logic fieldStart,
    input wire logic lineStart,
    input wire logic [8:0] lineCount,
    input wire logic fieldIndicator,
    input wire logic realtimeEvenField,
    input wire logic realtimeVerticalBlank,
    input wire logic sliceValid,
    output logic sliceReady,
    input wire logic [7:0] sliceByte,
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] outByte,
    output vbs_pkg::vbs_frame_s frameSetup,
    output vbs_pkg::vbs_status_s lineStatus,
    output vbs_pkg::vbs_cfg_s slicerCfg,
    output logic fieldOut,
    output logic blankOut
);
    localparam int NREG = 31;
    localparam int ICODE = 24;
    localparam int IHOR = 25;
    localparam int IVER = 26;
    localparam int IMSB = 27;
    localparam int IHDR = 29;
    localparam int ISEC = 30;

    if (FIFO_DEPTH < 2) begin : g_chk
        $error("vbs_slicer_control: FIFO_DEPTH too small");
    end

    // Writable bits of each register slot.
    function automatic logic [7:0] wrMask(input int i);
        if (i == 0) return `VBS_MASK_CTRL;
        if (i <= IVER) return 8'hff;
        if (i == IMSB) return `VBS_MASK_MSBS;
        if (i == IHDR) return `VBS_MASK_HEADER_ID;
        if (i == ISEC) return `VBS_MASK_SEC_ID;
        return 8'h00;
    endfunction : wrMask
    // Reset value of each register slot.
    function automatic logic [7:0] resetVal(input int i);
        if (i >= 1 && i <= 23) return `VBS_RST_LINE;
        if (i == ICODE) return `VBS_RST_FRAME_CODE;
        return `VBS_RST_OTHER;
    endfunction : resetVal
    // Framing setup for one data type.
    function automatic vbs_pkg::vbs_frame_s frameOf(
        input logic [3:0] dtype, input logic [7:0] ctrl,
        input logic [7:0] progCode);
        vbs_pkg::vbs_frame_s f;
        f = '0;
        f.exactCode = ctrl[`VBS_BIT_EXACT_CODE];
        f.searchStop = ctrl[`VBS_BIT_SEARCH_STOP];
        case (vbs_pkg::vbs_dtype_e'(dtype))
            vbs_pkg::TYPE_EURO_TEXT, vbs_pkg::TYPE_US_TEXT: begin
                f.code = `VBS_CODE_TEXT;
                f.codeLen = `VBS_LEN_BYTE;
                f.parityCheck = !ctrl[`VBS_BIT_PARITY_DIS];
            end
            vbs_pkg::TYPE_EURO_CAPTION, vbs_pkg::TYPE_US_CAPTION: begin
                f.code = `VBS_CODE_CAPTION;
                f.codeLen = `VBS_LEN_CAPTION;
            end
            vbs_pkg::TYPE_PROGRAM: begin
                f.code = `VBS_CODE_PROGRAM;
                f.codeLen = `VBS_LEN_PROGRAM;
            end
            vbs_pkg::TYPE_WIDE: begin
                f.code = `VBS_CODE_WIDE;
                f.codeLen = `VBS_LEN_WIDE;
            end
            vbs_pkg::TYPE_GEN_TEXT, vbs_pkg::TYPE_EURO_TIME,
            vbs_pkg::TYPE_US_TIME, vbs_pkg::TYPE_JP_TEXT,
            vbs_pkg::TYPE_JP_SWITCH: begin
                f.code = {16'h0000, progCode};
                f.codeLen = `VBS_LEN_BYTE;
            end
            default: f.codeLen = 5'h00;
        endcase
        return f;
    endfunction : frameOf
    // Byte substitution for recoded output.
    function automatic logic [7:0] recode(input logic [7:0] b,
                                          input logic en);
        if (en && b == `VBS_BYTE_LOW) return `VBS_BYTE_LOW_SUB;
        if (en && b == `VBS_BYTE_HIGH) return `VBS_BYTE_HIGH_SUB;
        return b;
    endfunction : recode
    logic [7:0] shadow_ff [NREG];
    logic [7:0] act_ff [NREG];
    logic [7:0] rdData_ff, outByte_ff;
    logic [7:0] ctrlAct, msbAct, hdrAct, entry, fifoIn, fifoOut;
    logic [4:0] regIdx, tableIdx;
    logic [8:0] verOffset;
    logic [9:0] effLine;
    logic [3:0] lineType;
    logic inRange, inTable, fieldSeen, refRealtime;
    logic fifoOutValid, fifoDrain, outValid_ff, fieldOut_ff, blankOut_ff;
    vbs_pkg::vbs_frame_s frame_ff;
    vbs_pkg::vbs_status_s status_ff;
    vbs_pkg::vbs_cfg_s cfg_ff;

    // Subaddress decode into register slots.
    assign inRange = subAddr >= `VBS_ADDR_CTRL && subAddr <= `VBS_ADDR_SEC_ID;
    assign regIdx = 5'(subAddr - `VBS_ADDR_CTRL);

    // Host side copies, written at any time.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NREG; i++) begin
                shadow_ff[i] <= resetVal(i);
            end
        end else begin
            for (int i = 0; i < NREG; i++) begin
                if (regWrite && inRange && regIdx == 5'(i)) begin
                    shadow_ff[i] <= wrData & wrMask(i);
                end
            end
        end
    end

    // Working copies follow the host copies only at a field start.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NREG; i++) begin
                act_ff[i] <= resetVal(i);
            end
        end else if (fieldStart) begin
            act_ff <= shadow_ff;
        end
    end

    // Read port returns host copies; unmapped subaddresses read zero.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= 8'h00;
        end else if (regRead) begin
            rdData_ff <= inRange ? shadow_ff[regIdx] : 8'h00;
        end
    end

    // Working setup fields and the line table lookup.
    assign ctrlAct = act_ff[0];
    assign msbAct = act_ff[IMSB];
    assign hdrAct = act_ff[IHDR];
    assign verOffset = {msbAct[`VBS_BIT_VER_MSB], act_ff[IVER]};
    assign effLine = {1'b0, lineCount} - {1'b0, verOffset};
    assign inTable = !effLine[9] && effLine[8:0] >= `VBS_LINE_FIRST
                     && effLine[8:0] <= `VBS_LINE_LAST;
    assign tableIdx = 5'(effLine[4:0] - 5'h01);
    assign entry = act_ff[tableIdx];
    assign fieldSeen = fieldIndicator ^ msbAct[`VBS_BIT_FIELD_INV];
    assign lineType = !inTable ? 4'hf
                      : (fieldSeen ? entry[3:0] : entry[7:4]);
    // Special identifiers force the reference; otherwise the bit decides.
    assign refRealtime = hdrAct[5:0] == `VBS_ID_SAV_RT ? 1'b1
                         : hdrAct[5:0] == `VBS_ID_SAV_TABLE ? 1'b0
                         : hdrAct[`VBS_BIT_REF_SEL];

    // Per-line framing setup, status and field/blank references.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frame_ff <= '0;
            status_ff <= '0;
            fieldOut_ff <= 1'b0;
            blankOut_ff <= 1'b0;
        end else if (lineStart) begin
            frame_ff <= frameOf(lineType, ctrlAct, act_ff[ICODE]);
            status_ff <= {fieldSeen, effLine[8:0], lineType};
            fieldOut_ff <= refRealtime ? realtimeEvenField
                                       : fieldSeen;
            blankOut_ff <= refRealtime ? realtimeVerticalBlank
                                       : lineType != 4'hf;
        end
    end

    // Static setup for slicer and formatter, refreshed every cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff.horOffset <= {msbAct[2:0], act_ff[IHOR]};
            cfg_ff.verOffset <= verOffset;
            cfg_ff.savEav <= hdrAct[5:0] == `VBS_ID_SAV_RT
                             || hdrAct[5:0] == `VBS_ID_SAV_TABLE;
            cfg_ff.headerId <= hdrAct[5:0];
            cfg_ff.secId <= act_ff[ISEC][5:0];
        end
    end

    // Sliced bytes are recoded on the way into the FIFO.
    assign fifoIn = recode(sliceByte, msbAct[`VBS_BIT_RECODE]);
    assign fifoDrain = !outValid_ff || outReady;
    vbs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .inValid(sliceValid),
        .inReady(sliceReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoDrain),
        .outData(fifoOut)
    );

    // Output register stage stalls the FIFO while the sink refuses.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outValid_ff <= 1'b0;
            outByte_ff <= 8'h00;
        end else if (fifoDrain) begin
            outValid_ff <= fifoOutValid;
            if (fifoOutValid) begin
                outByte_ff <= fifoOut;
            end
        end
    end

    assign rdData = rdData_ff;
    assign outValid = outValid_ff;
    assign outByte = outByte_ff;
    assign frameSetup = frame_ff;
    assign lineStatus = status_ff;
    assign slicerCfg = cfg_ff;
    assign fieldOut = fieldOut_ff;
    assign blankOut = blankOut_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence lineTaken(logic [3:0] t);
        lineStart && lineType == t;
    endsequence
    text_code_a: assert property (lineTaken(4'h0) or lineTaken(4'h4)
        |=> frameSetup.code == 24'h000027 && frameSetup.codeLen == 5'h08)
        else $error("teletext framing code wrong");
    caption_code_a: assert property (lineTaken(4'h1)
        |=> frameSetup.code == 24'h000001 && frameSetup.codeLen == 5'h03)
        else $error("caption framing pattern wrong");
    program_code_a: assert property (lineTaken(4'h2)
        |=> frameSetup.code == 24'h009951)
        else $error("program service code wrong");
    wide_code_a: assert property (lineTaken(4'h3)
        |=> frameSetup.code == 24'h1e3c1f)
        else $error("wide screen code wrong");
    prog_code_a: assert property (lineTaken(4'hd)
        |=> frameSetup.code[7:0] == $past(act_ff[ICODE]))
        else $error("programmable code not used");
    no_code_a: assert property (lineTaken(4'hf)
        |=> frameSetup.codeLen == 5'h00 && frameSetup.code == 24'h000000)
        else $error("active video has framing code");
    parity_check_a: assert property (lineTaken(4'h0)
        |=> frameSetup.parityCheck == !$past(ctrlAct[6]))
        else $error("parity check policy wrong");
    field_seen_a: assert property (lineStart
        |=> lineStatus.field == ($past(fieldIndicator) ^ $past(msbAct[7])))
        else $error("field indicator inversion wrong");
    recode_low_a: assert property (sliceByte == 8'h00 && msbAct[6]
        |-> fifoIn == 8'h03) else $error("recode of 00 missing");
    field_hold_a: assert property (!fieldStart
        |=> $stable(act_ff[ICODE]) && $stable(act_ff[0]))
        else $error("setup changed inside a field");
endmodule : vbs_slicer_control

// File: sim/vbs_video_src.sv
// Decoder core model: field and line strobes, real-time references, bytes.
// Assumes the bench calls its tasks by hierarchical name after reset.
`timescale 1ns/1ps

module vbs_video_src (
    input wire logic clock,
    input wire logic sliceReady,
    output logic fieldStart,
    output logic lineStart,
    output logic [8:0] lineCount,
    output logic fieldIndicator,
    output logic rtEven,
    output logic rtBlank,
    output logic sliceValid,
    output logic [7:0] sliceByte
);
    // Idle levels before any traffic.
    initial begin
        fieldStart = 1'b0;
        lineStart = 1'b0;
        lineCount = 9'h000;
        fieldIndicator = 1'b0;
        rtEven = 1'b0;
        rtBlank = 1'b0;
        sliceValid = 1'b0;
        sliceByte = 8'h00;
    end

    // One-cycle field strobe.
    task field_go();
        @(posedge clock);
        fieldStart <= 1'b1;
        @(posedge clock);
        fieldStart <= 1'b0;
    endtask : field_go

    // One-cycle line strobe; the field level is held until the next line.
    task line_go(input logic [8:0] c, input logic f);
        @(posedge clock);
        lineStart <= 1'b1;
        lineCount <= c;
        fieldIndicator <= f;
        @(posedge clock);
        lineStart <= 1'b0;
        lineCount <= ~c;
    endtask : line_go

    // Real-time even-field and blanking levels.
    task rt(input logic e, input logic b);
        @(posedge clock);
        rtEven <= e;
        rtBlank <= b;
    endtask : rt

    // Offers one byte for a few cycles; a full buffer refuses it.
    task send(input logic [7:0] b, output logic ok);
        ok = 1'b0;
        @(posedge clock);
        sliceValid <= 1'b1;
        sliceByte <= b;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clock);
            ok = (sliceReady === 1'b1);
        end
        sliceValid <= 1'b0;
        sliceByte <= ~b;
    endtask : send
endmodule : vbs_video_src

// File: sim/vbs_slicer_control_tb.sv
// Self-checking bench for the slicer setup block.
// Assumes the design files and the decoder core model are compiled first.
`timescale 1ns/1ps

module vbs_slicer_control_tb;
    localparam int DEPTH = 16;
    logic clock, nrst, regWrite, regRead, outValid, outReady, sliceReady;
    logic [7:0] subAddr, wrData, rdData, outByte, sliceByte;
    logic fieldStart, lineStart, fieldIndicator, rtEven, rtBlank;
    logic sliceValid, fieldOut, blankOut, ok;
    logic [8:0] lineCount;
    logic [28:0] f29;
    vbs_pkg::vbs_frame_s frameSetup;
    vbs_pkg::vbs_status_s lineStatus;
    vbs_pkg::vbs_cfg_s slicerCfg;
    int fail_count = 0;
    int num_checks = 0;
    int n;

    vbs_slicer_control #(.FIFO_DEPTH(DEPTH)) dut_u (.clock(clock),
        .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
        .subAddr(subAddr), .wrData(wrData), .rdData(rdData),
        .fieldStart(fieldStart), .lineStart(lineStart),
        .lineCount(lineCount), .fieldIndicator(fieldIndicator),
        .realtimeEvenField(rtEven), .realtimeVerticalBlank(rtBlank),
        .sliceValid(sliceValid), .sliceReady(sliceReady),
        .sliceByte(sliceByte), .outValid(outValid), .outReady(outReady),
        .outByte(outByte), .frameSetup(frameSetup),
        .lineStatus(lineStatus), .slicerCfg(slicerCfg),
        .fieldOut(fieldOut), .blankOut(blankOut));

    vbs_video_src vid_u (.clock(clock), .sliceReady(sliceReady),
        .fieldStart(fieldStart), .lineStart(lineStart),
        .lineCount(lineCount), .fieldIndicator(fieldIndicator),
        .rtEven(rtEven), .rtBlank(rtBlank), .sliceValid(sliceValid),
        .sliceByte(sliceByte));

    // Free-running 50 MHz clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task end_sim();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        subAddr <= a;
        wrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regRead <= 1'b1;
        subAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(posedge clock);
        #1 chk(rdData, e);
    endtask : rd

    // New field, then let the working copy settle.
    task nf();
        vid_u.field_go();
        repeat (2) @(posedge clock);
    endtask : nf

    task lk(input logic [8:0] c, input logic f, input logic [3:0] t);
        vid_u.line_go(c, f);
        @(posedge clock);
        #1 chk(lineStatus.dtype, t);
    endtask : lk

    // Framing code length and value expected for each data type.
    function automatic logic [28:0] fx(input logic [3:0] t);
        case (t)
            4'h0, 4'h4: fx = {5'h08, 24'h000027};
            4'h1, 4'h5: fx = {5'h03, 24'h000001};
            4'h2: fx = {5'h10, 24'h009951};
            4'h3: fx = {5'h18, 24'h1e3c1f};
            4'h8, 4'h9, 4'ha, 4'hd, 4'he: fx = {5'h08, 24'h0000a7};
            default: fx = 29'h0;
        endcase
    endfunction : fx

    function automatic logic [7:0] bv(input int k);
        bv = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : k[7:0];
    endfunction : bv

    task drain(input int cnt, input logic rc);
        int k;
        logic [7:0] e;
        k = 0;
        outReady <= 1'b1;
        repeat (4 * cnt + 8) begin
            @(posedge clock);
            if (outValid === 1'b1 && k < cnt) begin
                e = bv(k);
                if (rc && e == 8'h00) e = 8'h03;
                else if (rc && e == 8'hff) e = 8'hfc;
                chk(outByte, e);
                k++;
            end
        end
        outReady <= 1'b0;
        chk(k, cnt);
    endtask : drain

    // Hang guard, well beyond the expected run length.
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end

    // Main sequence.
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        subAddr = 8'h00;
        wrData = 8'h00;
        outReady = 1'b0;
        nrst = 1'b0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd(8'h40, 8'h00);
        rd(8'h41, 8'hff);
        rd(8'h57, 8'hff);
        rd(8'h58, 8'h40);
        rd(8'h5e, 8'h00);
        rd(8'h5f, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h70);
        wr(8'h5b, 8'hff);
        rd(8'h5b, 8'hd7);
        wr(8'h5d, 8'hff);
        rd(8'h5d, 8'hbf);
        wr(8'h5e, 8'hff);
        rd(8'h5e, 8'h3f);
        wr(8'h5b, 8'h00);
        wr(8'h5d, 8'h00);
        wr(8'h40, 8'h20);
        wr(8'h41, 8'h85);
        nf();
        lk(9'h002, 1'b0, 4'h8);
        chk(frameSetup.code, 24'h000040);
        wr(8'h58, 8'ha7);
        rd(8'h58, 8'ha7);
        for (int t = 0; t < 16; t++) begin
            wr(8'h41, {t[3:0], 4'h5});
            nf();
            lk(9'h002, 1'b0, t[3:0]);
            f29 = fx(t[3:0]);
            chk(frameSetup.codeLen, f29[28:24]);
            if (f29[28:24] != 5'h00) chk(frameSetup.code, f29[23:0]);
            chk(frameSetup.parityCheck, t == 0 || t == 4);
            chk(frameSetup.exactCode, 1'b1);
            chk(blankOut, t != 15);
        end
        wr(8'h41, 8'h03);
        wr(8'h40, 8'h50);
        nf();
        lk(9'h002, 1'b0, 4'h0);
        chk(frameSetup.parityCheck, 1'b0);
        chk(frameSetup.exactCode, 1'b0);
        chk(frameSetup.searchStop, 1'b1);
        wr(8'h40, 8'h20);
        lk(9'h002, 1'b1, 4'h3);
        chk(frameSetup.searchStop, 1'b1);
        chk(lineStatus.field, 1'b1);
        wr(8'h5b, 8'h80);
        nf();
        lk(9'h002, 1'b0, 4'h3);
        lk(9'h002, 1'b1, 4'h0);
        chk(frameSetup.searchStop, 1'b0);
        wr(8'h59, 8'h47);
        wr(8'h5a, 8'h03);
        wr(8'h5b, 8'h03);
        nf();
        #1 chk(slicerCfg.horOffset, 11'h347);
        chk(slicerCfg.verOffset, 9'h003);
        lk(9'h005, 1'b0, 4'h0);
        chk(lineStatus.line, 9'h002);
        lk(9'h004, 1'b0, 4'hf);
        wr(8'h5a, 8'h38);
        wr(8'h5b, 8'h10);
        wr(8'h5d, 8'h3e);
        wr(8'h5e, 8'h2a);
        vid_u.rt(1'b1, 1'b0);
        nf();
        #1 chk(slicerCfg.verOffset, 9'h138);
        chk(slicerCfg.savEav, 1'b1);
        chk(slicerCfg.headerId, 6'h3e);
        chk(slicerCfg.secId, 6'h2a);
        lk(9'h13a, 1'b0, 4'h0);
        chk(fieldOut, 1'b1);
        chk(blankOut, 1'b0);
        wr(8'h5d, 8'h3f);
        nf();
        lk(9'h13a, 1'b0, 4'h0);
        chk(fieldOut, 1'b0);
        chk(blankOut, 1'b1);
        wr(8'h5d, 8'h80);
        nf();
        #1 chk(slicerCfg.savEav, 1'b0);
        lk(9'h13a, 1'b0, 4'h0);
        chk(fieldOut, 1'b1);
        chk(blankOut, 1'b0);
        wr(8'h5b, 8'h40);
        nf();
        n = 0;
        ok = 1'b1;
        while (ok && n < 24) begin
            vid_u.send(bv(n), ok);
            if (ok) n++;
        end
        chk(n, DEPTH + 1);
        drain(n, 1'b1);
        wr(8'h5b, 8'h00);
        nf();
        vid_u.send(8'h00, ok);
        drain(1, 1'b0);
        end_sim();
    end
endmodule : vbs_slicer_control_tb
